// file: hdl/gpio_port_steer.sv
// two 8-bit gpio ports with apb registers and peripheral pin steering
// Notes on behaviour
// - direction bit 1 makes the pin input, output driver off
// - direction bit 0 drives the pin from the output latch
// - port a pin 5 is input only, its direction reads 1
// - pin levels register reads pins; writing it updates the latch
// - latch register write equals port write; read returns latch
// - port writes are read-modify-write into the latch
// - direction keeps driver control even for analog pins
// - digital read of an analog pin returns 0
// - analog select disables the digital input buffer
// - an enabled peripheral takes over its pin
// - steering never changes direction; overrides follow the peripheral
// - the deselected pin keeps normal port behaviour
// - steer0 bit 7: usart rx on b1, or b2
// - steer0 bit 6: spi1 out on b2, or a6
// - steer0 bit 5: spi1 select input on b5, or a5
// - steer0 bit 4: pwm2 b on b7, or a6
// - steer0 bit 3: capture2/pwm2 a on b6, or a7
// - steer0 bit 2: pwm1 d on b7, or a6
// - steer0 bit 1: pwm1 c on b6, or a7
// - steer0 bit 0: capture1/pwm1 a on b3, or b0
// - steer1 bit 0: usart tx clock on b2, or b5; other bits 0
//
// The placing of the registers and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module gpio_port_steer
    import gpio_steer_pkg::*;
#(
    parameter int W = PORT_W
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [W-1:0] PORT_A_IN,
    output logic [W-1:0] PORT_A_OUT,
    output logic [W-1:0] PORT_A_OE_N,
    input wire logic [W-1:0] PORT_B_IN,
    output logic [W-1:0] PORT_B_OUT,
    output logic [W-1:0] PORT_B_OE_N,
    // peripheral outputs: enable, data, direction (1 = input)
    input wire logic USART_RX_SYNC_DATA_EN,
    input wire logic USART_RX_SYNC_DATA_OUT,
    input wire logic USART_RX_SYNC_DATA_DIR,
    output logic USART_RX_SYNC_DATA_IN,
    input wire logic USART_TX_SYNC_CLOCK_EN,
    input wire logic USART_TX_SYNC_CLOCK_OUT,
    input wire logic USART_TX_SYNC_CLOCK_DIR,
    output logic USART_TX_SYNC_CLOCK_IN,
    input wire logic SPI1_DATA_OUT_EN,
    input wire logic SPI1_DATA_OUT,
    output logic SPI1_SLAVE_SELECT_IN,
    input wire logic PWM2_OUT_B_EN,
    input wire logic PWM2_OUT_B,
    input wire logic CAPTURE2_PWM2_OUT_A_EN,
    input wire logic CAPTURE2_PWM2_OUT_A,
    input wire logic CAPTURE2_PWM2_OUT_A_DIR,
    output logic CAPTURE2_PWM2_IN,
    input wire logic PWM1_OUT_D_EN,
    input wire logic PWM1_OUT_D,
    input wire logic PWM1_OUT_C_EN,
    input wire logic PWM1_OUT_C,
    input wire logic CAPTURE1_PWM1_OUT_A_EN,
    input wire logic CAPTURE1_PWM1_OUT_A,
    input wire logic CAPTURE1_PWM1_OUT_A_DIR,
    output logic CAPTURE1_PWM1_IN
);
    // software-visible registers, one byte each
    logic [W-1:0] dir_a_q;
    logic [W-1:0] dir_b_q;
    logic [W-1:0] lat_a_q;
    logic [W-1:0] lat_b_q;
    logic [W-1:0] ana_a_q;
    logic [W-1:0] ana_b_q;
    logic [7:0] steer0_q;
    logic [7:0] steer1_q;
    // pin levels as software sees them, analog pins already zeroed
    logic [W-1:0] lvl_a;
    logic [W-1:0] lvl_b;
    // per-pin peripheral override: enable, data, direction
    logic [W-1:0] pen_a;
    logic [W-1:0] pout_a;
    logic [W-1:0] pdir_a;
    logic [W-1:0] pen_b;
    logic [W-1:0] pout_b;
    logic [W-1:0] pdir_b;
    // bus decode
    logic wr;
    logic rd;
    logic hit;
    logic [31:0] rdata_d;

    // zero-wait slave: every access ends in its first access cycle;
    // no error response, so a stray address is silently ignored
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd = PSEL & ~PENABLE & ~PWRITE; // read setup cycle
    assign PREADY = 1'b1;
    assign PSLVERR = 1'b0;

    // a whole-byte write only; a write with PSTRB[0] clear leaves lane 0 alone
    function automatic logic [7:0] merge(input logic [7:0] old, input logic [31:0] wd, input logic s);
        merge = s ? wd[7:0] : old;
    endfunction

    // direction registers; the input-only pin is forced to 1
    // a 0 written to the input-only bit is dropped, so it reads 1
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_a_q <= RST_DIRECTION;
            dir_b_q <= RST_DIRECTION;
        end else if (wr) begin
            if (PADDR == OFS_A_DIRECTION) begin
                dir_a_q <= merge(dir_a_q, PWDATA, PSTRB[0]);
                dir_a_q[INPUT_ONLY_PIN] <= 1'b1;
            end
            if (PADDR == OFS_B_DIRECTION) begin
                dir_b_q <= merge(dir_b_q, PWDATA, PSTRB[0]);
            end
        end
    end

    // output latches: written from either the pin or the latch address.
    // the byte write replaces all bits, i.e. the write step of the
    // read-modify-write; a cpu doing bit ops reads pins first
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            lat_a_q <= RST_LATCH;
            lat_b_q <= RST_LATCH;
        end else if (wr) begin
            if (PADDR == OFS_A_PIN_LEVELS || PADDR == OFS_A_OUTPUT_LATCH) begin
                lat_a_q <= merge(lat_a_q, PWDATA, PSTRB[0]) & LATCH_A_MASK;
            end
            if (PADDR == OFS_B_PIN_LEVELS || PADDR == OFS_B_OUTPUT_LATCH) begin
                lat_b_q <= merge(lat_b_q, PWDATA, PSTRB[0]);
            end
        end
    end

    // analog select registers
    // port a bits 7:5 have no analog function and read 0
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            ana_a_q <= RST_ANALOG_A;
            ana_b_q <= RST_ANALOG_B;
        end else if (wr) begin
            if (PADDR == OFS_A_ANALOG_SELECT) begin
                ana_a_q <= merge(ana_a_q, PWDATA, PSTRB[0]) & ANALOG_A_MASK;
            end
            if (PADDR == OFS_B_ANALOG_SELECT) begin
                ana_b_q <= merge(ana_b_q, PWDATA, PSTRB[0]);
            end
        end
    end

    // steering registers; steering never touches direction bits
    // steer1 keeps only its lowest bit, the rest read 0
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            steer0_q <= RST_STEER;
            steer1_q <= RST_STEER;
        end else if (wr) begin
            if (PADDR == OFS_STEER_0) begin
                steer0_q <= merge(steer0_q, PWDATA, PSTRB[0]);
            end
            if (PADDR == OFS_STEER_1) begin
                steer1_q <= merge(steer1_q, PWDATA, PSTRB[0]) & STEER_1_MASK;
            end
        end
    end

    // read mux; unmapped addresses read zero
    always_comb begin
        rdata_d = 32'h0000_0000;
        hit = 1'b1;
        unique case (PADDR)
            OFS_A_DIRECTION: rdata_d[7:0] = dir_a_q;
            OFS_A_PIN_LEVELS: rdata_d[7:0] = lvl_a;
            OFS_A_OUTPUT_LATCH: rdata_d[7:0] = lat_a_q;
            OFS_A_ANALOG_SELECT: rdata_d[7:0] = ana_a_q;
            OFS_B_DIRECTION: rdata_d[7:0] = dir_b_q;
            OFS_B_PIN_LEVELS: rdata_d[7:0] = lvl_b;
            OFS_B_OUTPUT_LATCH: rdata_d[7:0] = lat_b_q;
            OFS_B_ANALOG_SELECT: rdata_d[7:0] = ana_b_q;
            OFS_STEER_0: rdata_d[7:0] = steer0_q;
            OFS_STEER_1: rdata_d[7:0] = steer1_q;
            // gaps and the top of the map fall here
            default: hit = 1'b0;
        endcase
    end

    // read data registered on the setup cycle, stable through access
    // pin levels are the ones present at the setup edge
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd) begin
            PRDATA <= hit ? rdata_d : 32'h0000_0000;
        end
    end

    // route peripheral overrides to the selected pin only; the other
    // candidate pin gets no override and stays a plain port pin
    // shared pins: later assignments win, so tx clock beats spi1 out
    // beats rx data on b2, pwm2 b beats pwm1 d, capture2 beats pwm1 c
    always_comb begin
        pen_a = '0;
        pout_a = '0;
        pdir_a = '1;
        pen_b = '0;
        pout_b = '0;
        pdir_b = '1;
        // capture1/pwm1 a
        if (steer0_q[SEL_CAP1]) begin
            pen_b[0] = CAPTURE1_PWM1_OUT_A_EN;
            pout_b[0] = CAPTURE1_PWM1_OUT_A;
            pdir_b[0] = CAPTURE1_PWM1_OUT_A_DIR;
        end else begin
            pen_b[3] = CAPTURE1_PWM1_OUT_A_EN;
            pout_b[3] = CAPTURE1_PWM1_OUT_A;
            pdir_b[3] = CAPTURE1_PWM1_OUT_A_DIR;
        end

        // usart receive / sync data
        if (steer0_q[SEL_USART_RX]) begin
            pen_b[2] = USART_RX_SYNC_DATA_EN;
            pout_b[2] = USART_RX_SYNC_DATA_OUT;
            pdir_b[2] = USART_RX_SYNC_DATA_DIR;
        end else begin
            pen_b[1] = USART_RX_SYNC_DATA_EN;
            pout_b[1] = USART_RX_SYNC_DATA_OUT;
            pdir_b[1] = USART_RX_SYNC_DATA_DIR;
        end

        // spi1 data out, always an output when enabled; later sources win on b2 and a6
        if (steer0_q[SEL_SPI1_OUT] && SPI1_DATA_OUT_EN) begin
            pen_a[6] = 1'b1;
            pout_a[6] = SPI1_DATA_OUT;
            pdir_a[6] = 1'b0;
        end else if (SPI1_DATA_OUT_EN) begin
            pen_b[2] = 1'b1;
            pout_b[2] = SPI1_DATA_OUT;
            pdir_b[2] = 1'b0;
        end

        // usart transmit / sync clock
        if (steer1_q[SEL_USART_TX] && USART_TX_SYNC_CLOCK_EN) begin
            pen_b[5] = 1'b1;
            pout_b[5] = USART_TX_SYNC_CLOCK_OUT;
            pdir_b[5] = USART_TX_SYNC_CLOCK_DIR;
        end else if (USART_TX_SYNC_CLOCK_EN) begin
            pen_b[2] = 1'b1;
            pout_b[2] = USART_TX_SYNC_CLOCK_OUT;
            pdir_b[2] = USART_TX_SYNC_CLOCK_DIR;
        end

        // pwm1 d, lower priority than pwm2 b on shared pins
        if (steer0_q[SEL_PWM1_D] && PWM1_OUT_D_EN) begin
            pen_a[6] = 1'b1;
            pout_a[6] = PWM1_OUT_D;
            pdir_a[6] = 1'b0;
        end else if (PWM1_OUT_D_EN) begin
            pen_b[7] = 1'b1;
            pout_b[7] = PWM1_OUT_D;
            pdir_b[7] = 1'b0;
        end

        // pwm2 b comes last on a6 and b7, so it wins there
        if (steer0_q[SEL_PWM2_B] && PWM2_OUT_B_EN) begin
            pen_a[6] = 1'b1;
            pout_a[6] = PWM2_OUT_B;
            pdir_a[6] = 1'b0;
        end else if (PWM2_OUT_B_EN) begin
            pen_b[7] = 1'b1;
            pout_b[7] = PWM2_OUT_B;
            pdir_b[7] = 1'b0;
        end

        // pwm1 c then capture2/pwm2 a
        if (steer0_q[SEL_PWM1_C] && PWM1_OUT_C_EN) begin
            pen_a[7] = 1'b1;
            pout_a[7] = PWM1_OUT_C;
            pdir_a[7] = 1'b0;
        end else if (PWM1_OUT_C_EN) begin
            pen_b[6] = 1'b1;
            pout_b[6] = PWM1_OUT_C;
            pdir_b[6] = 1'b0;
        end

        // capture2 comes last on a7 and b6, so it wins there
        if (steer0_q[SEL_CAP2] && CAPTURE2_PWM2_OUT_A_EN) begin
            pen_a[7] = 1'b1;
            pout_a[7] = CAPTURE2_PWM2_OUT_A;
            pdir_a[7] = CAPTURE2_PWM2_OUT_A_DIR;
        end else if (CAPTURE2_PWM2_OUT_A_EN) begin
            pen_b[6] = 1'b1;
            pout_b[6] = CAPTURE2_PWM2_OUT_A;
            pdir_b[6] = CAPTURE2_PWM2_OUT_A_DIR;
        end
    end

    // input-direction peripheral taps follow the steering too
    // an analog-selected pin hands the peripheral a 0 as well
    always_comb begin
        USART_RX_SYNC_DATA_IN = steer0_q[SEL_USART_RX] ? lvl_b[2] : lvl_b[1];
        SPI1_SLAVE_SELECT_IN = steer0_q[SEL_SPI1_SS] ? lvl_a[5] : lvl_b[5];
        USART_TX_SYNC_CLOCK_IN = steer1_q[SEL_USART_TX] ? lvl_b[5] : lvl_b[2];
        CAPTURE1_PWM1_IN = steer0_q[SEL_CAP1] ? lvl_b[0] : lvl_b[3];
        CAPTURE2_PWM2_IN = steer0_q[SEL_CAP2] ? lvl_a[7] : lvl_b[6];
    end

    // one pin cell per bit of each port
    // pin a5 never takes a peripheral: it has no output driver
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_pin
            gpio_pin_cell u_a (
                .dir_bit(dir_a_q[i]),
                .latch_bit(lat_a_q[i]),
                .analog_bit(ana_a_q[i]),
                .periph_en(pen_a[i] & (i != INPUT_ONLY_PIN)),
                .periph_out(pout_a[i]),
                .periph_dir(pdir_a[i]),
                .pin_in(PORT_A_IN[i]),
                .pin_out(PORT_A_OUT[i]),
                .pin_oe_n(PORT_A_OE_N[i]),
                .level(lvl_a[i])
            );
            gpio_pin_cell u_b (
                .dir_bit(dir_b_q[i]),
                .latch_bit(lat_b_q[i]),
                .analog_bit(ana_b_q[i]),
                .periph_en(pen_b[i]),
                .periph_out(pout_b[i]),
                .periph_dir(pdir_b[i]),
                .pin_in(PORT_B_IN[i]),
                .pin_out(PORT_B_OUT[i]),
                .pin_oe_n(PORT_B_OE_N[i]),
                .level(lvl_b[i])
            );
        end
    endgenerate
endmodule

// file: hdl/gpio_steer_pkg.sv
// constants shared by the gpio port and its pin steering logic
package gpio_steer_pkg;
    localparam int PORT_W = 8;
    // register byte offsets (no offsets are printed, these are assigned)
    localparam logic [7:0] OFS_A_DIRECTION = 8'h00;
    localparam logic [7:0] OFS_A_PIN_LEVELS = 8'h04;
    localparam logic [7:0] OFS_A_OUTPUT_LATCH = 8'h08;
    localparam logic [7:0] OFS_A_ANALOG_SELECT = 8'h0c;
    localparam logic [7:0] OFS_B_DIRECTION = 8'h10;
    localparam logic [7:0] OFS_B_PIN_LEVELS = 8'h14;
    localparam logic [7:0] OFS_B_OUTPUT_LATCH = 8'h18;
    localparam logic [7:0] OFS_B_ANALOG_SELECT = 8'h1c;
    localparam logic [7:0] OFS_STEER_0 = 8'h20;
    localparam logic [7:0] OFS_STEER_1 = 8'h24;
    // reset values
    localparam logic [7:0] RST_DIRECTION = 8'hff;
    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_ANALOG_A = 8'h1f;
    localparam logic [7:0] RST_ANALOG_B = 8'hff;
    localparam logic [7:0] RST_STEER = 8'h00;
    // implemented bits
    localparam logic [7:0] ANALOG_A_MASK = 8'h1f;
    localparam logic [7:0] LATCH_A_MASK = 8'hdf;
    localparam logic [7:0] STEER_1_MASK = 8'h01;
    localparam int INPUT_ONLY_PIN = 5;
    // steering register 0 field positions
    localparam int SEL_USART_RX = 7;
    localparam int SEL_SPI1_OUT = 6;
    localparam int SEL_SPI1_SS = 5;
    localparam int SEL_PWM2_B = 4;
    localparam int SEL_CAP2 = 3;
    localparam int SEL_PWM1_D = 2;
    localparam int SEL_PWM1_C = 1;
    localparam int SEL_CAP1 = 0;
    // steering register 1 field position
    localparam int SEL_USART_TX = 0;
endpackage

// file: hdl/gpio_pin_cell.sv
// one port pin: direction, latch, override, analog input gating
`timescale 1ns/1ps
module gpio_pin_cell
    import gpio_steer_pkg::*;
(
    input wire logic dir_bit,
    input wire logic latch_bit,
    input wire logic analog_bit,
    input wire logic periph_en,
    input wire logic periph_out,
    input wire logic periph_dir,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe_n,
    output logic level
);
    // peripheral takes over the pin while enabled
    always_comb begin
        if (periph_en) begin
            pin_out = periph_out;
            pin_oe_n = periph_dir;
        end else begin
            pin_out = latch_bit;
            pin_oe_n = dir_bit;
        end
    end

    // analog pins turn off the digital input buffer and read zero
    assign level = pin_in & ~analog_bit;
endmodule

// file: tb/gpio_port_steer_properties.sv
// concurrent checks on the port registers and steered pin paths
`timescale 1ns/1ps
module gpio_port_steer_props
    import gpio_steer_pkg::*;
#(
    parameter int W = PORT_W
) (
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    input wire logic [3:0] PSTRB,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    input wire logic [W-1:0] PORT_A_IN,
    input wire logic [W-1:0] PORT_A_OUT,
    input wire logic [W-1:0] PORT_A_OE_N,
    input wire logic [W-1:0] PORT_B_IN,
    input wire logic USART_RX_SYNC_DATA_IN,
    input wire logic USART_TX_SYNC_CLOCK_IN,
    input wire logic SPI1_SLAVE_SELECT_IN,
    input wire logic CAPTURE1_PWM1_IN,
    input wire logic CAPTURE2_PWM2_IN
);
    logic [7:0] dir_a_q, lat_a_q, an_b_q, s0_q, s1_q;
    logic wr_en, rd_setup;
    assign wr_en = PSEL && PENABLE && PWRITE && PSTRB[0];
    assign rd_setup = PSEL && !PENABLE && !PWRITE;
    // shadow copies, only the bits the pin paths depend on are trusted
    always_ff @(posedge CLK_SYS or posedge SYS_RST) begin
        if (SYS_RST) begin
            dir_a_q <= RST_DIRECTION;
            lat_a_q <= RST_LATCH;
            an_b_q <= RST_ANALOG_B;
            s0_q <= RST_STEER;
            s1_q <= RST_STEER;
        end else if (wr_en) begin
            case (PADDR)
                OFS_A_DIRECTION: dir_a_q <= PWDATA[7:0];
                OFS_A_PIN_LEVELS, OFS_A_OUTPUT_LATCH: lat_a_q <= PWDATA[7:0];
                OFS_B_ANALOG_SELECT: an_b_q <= PWDATA[7:0];
                OFS_STEER_0: s0_q <= PWDATA[7:0];
                OFS_STEER_1: s1_q <= PWDATA[7:0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (SYS_RST);
    a_bus_answer: assert property (PREADY && !PSLVERR)
        else $error("bus answer not ready or error");
    a_dir_driver: assert property (PORT_A_OE_N[4:0] == dir_a_q[4:0])
        else $error("driver enable differs from direction");
    a_latch_drive: assert property ((~dir_a_q[4:0] & (PORT_A_OUT[4:0] ^ lat_a_q[4:0])) == 5'h00)
        else $error("driven pin differs from latch");
    a_pin5_input: assert property (rd_setup && PADDR == OFS_A_DIRECTION |=> PRDATA[5] && PORT_A_OE_N[5])
        else $error("input-only pin shows output");
    a_pins_read: assert property (rd_setup && PADDR == OFS_A_PIN_LEVELS |=>
        (PRDATA[7:0] & 8'he0) == ($past(PORT_A_IN) & 8'he0))
        else $error("pin read differs from pins");
    a_read_unmapped: assert property (rd_setup && PADDR > OFS_STEER_1 |=> PRDATA == 32'h0)
        else $error("unmapped read not zero");
    a_rx_steer: assert property (USART_RX_SYNC_DATA_IN ==
        (s0_q[SEL_USART_RX] ? PORT_B_IN[2] & !an_b_q[2] : PORT_B_IN[1] & !an_b_q[1]))
        else $error("rx data path wrong");
    a_ss_steer: assert property (SPI1_SLAVE_SELECT_IN ==
        (s0_q[SEL_SPI1_SS] ? PORT_A_IN[5] : PORT_B_IN[5] & !an_b_q[5]))
        else $error("select path wrong");
    a_tx_steer: assert property (USART_TX_SYNC_CLOCK_IN ==
        (s1_q[SEL_USART_TX] ? PORT_B_IN[5] & !an_b_q[5] : PORT_B_IN[2] & !an_b_q[2]))
        else $error("tx clock path wrong");
    a_cap1_steer: assert property (CAPTURE1_PWM1_IN ==
        (s0_q[SEL_CAP1] ? PORT_B_IN[0] & !an_b_q[0] : PORT_B_IN[3] & !an_b_q[3]))
        else $error("capture1 path wrong");
    a_cap2_steer: assert property (CAPTURE2_PWM2_IN ==
        (s0_q[SEL_CAP2] ? PORT_A_IN[7] : PORT_B_IN[6] & !an_b_q[6]))
        else $error("capture2 path wrong");
endmodule
bind gpio_port_steer gpio_port_steer_props #(.W(W)) gpio_port_steer_props_i (.CLK_SYS(CLK_SYS),
    .SYS_RST(SYS_RST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
    .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_A_IN(PORT_A_IN),
    .PORT_A_OUT(PORT_A_OUT), .PORT_A_OE_N(PORT_A_OE_N), .PORT_B_IN(PORT_B_IN),
    .USART_RX_SYNC_DATA_IN(USART_RX_SYNC_DATA_IN), .USART_TX_SYNC_CLOCK_IN(USART_TX_SYNC_CLOCK_IN),
    .SPI1_SLAVE_SELECT_IN(SPI1_SLAVE_SELECT_IN), .CAPTURE1_PWM1_IN(CAPTURE1_PWM1_IN),
    .CAPTURE2_PWM2_IN(CAPTURE2_PWM2_IN));

// file: tb/pin_board.sv
// board side of the package pins: resolves each pin level
`timescale 1ns/1ps
module pin_board (
    input wire logic [7:0] out_a,
    input wire logic [7:0] oe_n_a,
    input wire logic [7:0] out_b,
    input wire logic [7:0] oe_n_b,
    input wire logic [7:0] ext_a,
    input wire logic [7:0] ext_b,
    output logic [7:0] lvl_a,
    output logic [7:0] lvl_b
);
    // released pins show the board's own drive, never a stale port value
    assign lvl_a = (~oe_n_a & out_a) | (oe_n_a & ext_a);
    assign lvl_b = (~oe_n_b & out_b) | (oe_n_b & ext_b);
endmodule

// file: tb/test_gpio_port_steer.sv
// self-checking bench for the gpio port with pin steering
`timescale 1ns/1ps
module test_gpio_port_steer;
    import gpio_steer_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, ext_a, ext_b, out_a, oe_n_a, out_b, oe_n_b, lvl_a, lvl_b, steer;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [19:0] per;
    int n_errors, total_checks, seed, i, k;
    int mreg[10];
    gpio_port_steer gpio_port_steer_i (.CLK_SYS(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .PORT_A_IN(lvl_a), .PORT_A_OUT(out_a), .PORT_A_OE_N(oe_n_a), .PORT_B_IN(lvl_b),
        .PORT_B_OUT(out_b), .PORT_B_OE_N(oe_n_b), .USART_RX_SYNC_DATA_EN(per[0]),
        .USART_RX_SYNC_DATA_OUT(per[1]), .USART_RX_SYNC_DATA_DIR(per[2]), .USART_RX_SYNC_DATA_IN(),
        .USART_TX_SYNC_CLOCK_EN(per[3]), .USART_TX_SYNC_CLOCK_OUT(per[4]), .USART_TX_SYNC_CLOCK_DIR(per[5]),
        .USART_TX_SYNC_CLOCK_IN(), .SPI1_DATA_OUT_EN(per[6]), .SPI1_DATA_OUT(per[7]), .SPI1_SLAVE_SELECT_IN(),
        .PWM2_OUT_B_EN(per[8]), .PWM2_OUT_B(per[9]), .CAPTURE2_PWM2_OUT_A_EN(per[10]),
        .CAPTURE2_PWM2_OUT_A(per[11]), .CAPTURE2_PWM2_OUT_A_DIR(per[12]), .CAPTURE2_PWM2_IN(),
        .PWM1_OUT_D_EN(per[13]), .PWM1_OUT_D(per[14]), .PWM1_OUT_C_EN(per[15]), .PWM1_OUT_C(per[16]),
        .CAPTURE1_PWM1_OUT_A_EN(per[17]), .CAPTURE1_PWM1_OUT_A(per[18]), .CAPTURE1_PWM1_OUT_A_DIR(per[19]),
        .CAPTURE1_PWM1_IN());
    pin_board pin_board_i (.out_a(out_a), .oe_n_a(oe_n_a), .out_b(out_b), .oe_n_b(oe_n_b), .ext_a(ext_a),
        .ext_b(ext_b), .lvl_a(lvl_a), .lvl_b(lvl_b));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // one apb transfer; an idle cycle after it keeps strobes single-driven
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    // model: pins register shows resolved levels, analog pins read low
    function automatic logic [7:0] mexp(input int r);
        logic [7:0] d, l, n, e;
        d = 8'(mreg[r - 1]);
        l = 8'(mreg[r + 1]);
        n = 8'(mreg[r + 2]);
        e = (r == 1) ? ext_a : ext_b;
        return ((~d & l) | (d & e)) & ~n;
    endfunction
    task automatic mrd(input int r);
        apb(1'b0, 8'(4 * r), 32'h0);
        check(rd, {24'h0, (r == 1 || r == 5) ? mexp(r) : 8'(mreg[r])});
    endtask
    task automatic mwr(input int r, input logic [7:0] v);
        apb(1'b1, 8'(4 * r), {24'h0, v});
        case (r)
            0: mreg[0] = v | 8'h20;
            1, 2: mreg[2] = v & LATCH_A_MASK;
            3: mreg[3] = v & ANALOG_A_MASK;
            5, 6: mreg[6] = v;
            9: mreg[9] = v & STEER_1_MASK;
            default: mreg[r] = v;
        endcase
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        wrap_up();
    end
    initial begin
        seed = 32'h6320af2d;
        {rst, psel, penable, pwrite, paddr, pwdata, pstrb, per} = {1'b1, 43'h0, 4'h1, 20'h0};
        {ext_a, ext_b, n_errors, total_checks} = '0;
        mreg = '{8'hff, 0, 0, 8'h1f, 8'hff, 0, 0, 8'hff, 0, 0};
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        // reset values first, then random settings read back each round
        for (k = 0; k < 9; k++) begin
            for (i = 0; i < 10; i++) mrd(i);
            ext_a <= 8'($random(seed));
            ext_b <= 8'($random(seed));
            // analog first, so direction keeps analog pins as inputs
            for (i = 9; i >= 0; i--) mwr(i, 8'($random(seed) | ((i == 0 || i == 4) ? mreg[i + 3] : 0)));
        end
        for (i = 0; i < 10; i++) mrd(i);
        apb(1'b1, 8'h40, 32'h000000a5);
        apb(1'b0, 8'h40, 32'h0);
        check(rd, 32'h0);
        for (i = 0; i < 10; i++) mrd(i);
        mwr(3, 8'h00);
        mwr(0, 8'h60);
        mwr(4, 8'hff);
        // spi data out moved between b2 and a6; the other pin stays a port pin
        for (k = 0; k < 2; k++) begin
            mwr(8, k ? 8'h40 : 8'h00);
            per <= 20'h000c0;
            @(posedge clk);
            check({oe_n_a[6], oe_n_b[2]}, k ? 2'b01 : 2'b10);
            check(k ? out_a[6] : out_b[2], 1'b1);
            mrd(0);
            mrd(4);
        end
        // random peripheral traffic under the steering paths
        for (k = 0; k < 40; k++) begin
            per <= 20'($random(seed));
            ext_a <= 8'($random(seed));
            ext_b <= 8'($random(seed));
            mwr(8 + k % 2, 8'($random(seed)));
            mwr(7, 8'($random(seed)));
            // a6, b6, b7 are port inputs and a7 an output: only overrides move the enables
            steer = 8'(mreg[8]);
            check(oe_n_a[6], {~(steer[4] & per[8] | steer[2] & per[13] | steer[6] & per[6])});
            check(oe_n_b[7], {~(~steer[4] & per[8] | ~steer[2] & per[13])});
            check(oe_n_a[7], {(steer[3] & per[10]) ? per[12] : 1'b0});
            check(oe_n_b[6], {(~steer[3] & per[10]) ? per[12] : ~(~steer[1] & per[15])});
            mrd(8 + k % 2);
        end
        wrap_up();
    end
endmodule
